// >>> hw/octal_shift_register_bus_io.sv
`timescale 1ns/1ps

module octal_shift_register_bus_io
  import shreg_pkg::*;
#(
  parameter bit RIGHT_ONLY  = 1'b0,
  parameter bit ASYNC_CLEAR = 1'b0
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              shift_clk,
  input  wire logic              clear_n,
  input  wire logic              left_serial_in,
  input  wire logic              right_serial_in,
  input  wire logic              serial_in_zero,
  input  wire logic              serial_in_one,
  input  wire logic [DATA_W-1:0] bus_in,
  output logic      [DATA_W-1:0] bus_out,
  output logic      [DATA_W-1:0] bus_oe_n,
  output logic                   low_end_serial_out,
  output logic                   high_end_serial_out
);

  function automatic logic [DATA_W-1:0] shift_up(
    input logic [DATA_W-1:0] q,
    input logic              fill
  );
    shift_up = {q[DATA_W-2:0], fill};
  endfunction

  function automatic logic [DATA_W-1:0] shift_down(
    input logic [DATA_W-1:0] q,
    input logic              fill
  );
    shift_down = {fill, q[DATA_W-1:1]};
  endfunction

  // Pin synchronisers: every pin sees two flops before use
  logic [DATA_W-1:0] bus_s1;
  logic [DATA_W-1:0] bus_s2;
  logic [PIN_W-1:0]  pin_s1;
  logic [PIN_W-1:0]  pin_s2;
  logic              clk_seen;
  logic [DATA_W-1:0] next_bus_s1;
  logic [DATA_W-1:0] next_bus_s2;
  logic [PIN_W-1:0]  next_pin_s1;
  logic [PIN_W-1:0]  next_pin_s2;
  logic              next_clk_seen;

  // Only the second stage feeds logic; the first may be metastable
  always_comb begin
    next_bus_s1          = bus_in;
    next_bus_s2          = bus_s1;
    next_pin_s1          = '0;
    next_pin_s1[PIN_CLK] = shift_clk;
    next_pin_s1[PIN_CLR] = clear_n;
    next_pin_s1[PIN_SL]  = left_serial_in;
    next_pin_s1[PIN_SR]  = right_serial_in;
    next_pin_s1[PIN_D0]  = serial_in_zero;
    next_pin_s1[PIN_D1]  = serial_in_one;
    next_pin_s2          = pin_s1;
    next_clk_seen        = pin_s2[PIN_CLK];
  end

  // Reset to low: an idle-low shift clock gives no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_s1   <= '0;
      bus_s2   <= '0;
      pin_s1   <= '0;
      pin_s2   <= '0;
      clk_seen <= 1'b0;
    end else begin
      bus_s1   <= next_bus_s1;
      bus_s2   <= next_bus_s2;
      pin_s1   <= next_pin_s1;
      pin_s2   <= next_pin_s2;
      clk_seen <= next_clk_seen;
    end
  end

  logic clk_sync;
  logic clr_n_sync;
  logic sl_sync;
  logic sr_sync;
  logic d0_sync;
  logic d1_sync;

  assign clk_sync   = pin_s2[PIN_CLK];
  assign clr_n_sync = pin_s2[PIN_CLR];
  assign sl_sync    = pin_s2[PIN_SL];
  assign sr_sync    = pin_s2[PIN_SR];
  assign d0_sync    = pin_s2[PIN_D0];
  assign d1_sync    = pin_s2[PIN_D1];

  // APB slave, zero wait states
  ctrl_t ctrl;
  ctrl_t next_ctrl;
  logic  wr_fire;
  logic  rd_fire;
  logic  step_req;
  logic  addr_ok;

  assign pready  = 1'b1;
  assign wr_fire = psel && penable && pwrite;
  assign rd_fire = psel && penable && !pwrite;
  assign addr_ok = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR)
                   || (paddr == STEP_ADDR);
  assign pslverr = psel && penable && !addr_ok;
  assign step_req = wr_fire && (paddr == STEP_ADDR);

  always_comb begin
    next_ctrl = ctrl;
    if (wr_fire && paddr == CTRL_ADDR) begin
      next_ctrl = ctrl_t'(pwdata[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_t'(CTRL_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Register core
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] next_q;
  logic              edge_hit;
  logic              both_sel;
  logic              bus_hiz;
  op_t               op;

  // A software step counts as an edge of the shift clock; with a pin edge in the same cycle it gives one step
  assign edge_hit = (clk_sync && !clk_seen) || step_req;
  assign both_sel = ctrl.mode_sel_low && ctrl.mode_sel_high;

  // Right-shift variant: clear is a level and needs no edge
  function automatic op_t decode_right(
    input ctrl_t c,
    input logic  clr_n,
    input logic  hit
  );
    decode_right = OP_NONE;
    if (!clr_n) begin
      decode_right = OP_CLEAR;
    end else if (!hit) begin
      decode_right = OP_NONE;
    end else if (c.hold) begin
      decode_right = OP_HOLD;
    end else if (!c.serial_par) begin
      decode_right = OP_LOAD;
    end else if (c.sign_extend_n) begin
      decode_right = OP_SHIFT_UP;
    end else begin
      decode_right = OP_ARITH;
    end
  endfunction

  // Universal variant: a load outranks the synchronous clear
  function automatic op_t decode_universal(
    input ctrl_t c,
    input logic  clr_n,
    input logic  hit,
    input logic  both
  );
    decode_universal = OP_NONE;
    if (ASYNC_CLEAR && !clr_n) begin
      decode_universal = OP_CLEAR;
    end else if (!hit) begin
      decode_universal = OP_NONE;
    end else if (both) begin
      decode_universal = OP_LOAD;
    end else if (!clr_n) begin
      decode_universal = OP_CLEAR;
    end else if (c.mode_sel_high) begin
      decode_universal = OP_SHIFT_UP;
    end else if (c.mode_sel_low) begin
      decode_universal = OP_SHIFT_DOWN;
    end else begin
      decode_universal = OP_HOLD;
    end
  endfunction

  always_comb begin
    op = OP_NONE;
    if (RIGHT_ONLY) begin
      op = decode_right(ctrl, clr_n_sync, edge_hit);
    end else begin
      op = decode_universal(ctrl, clr_n_sync, edge_hit, both_sel);
    end
  end

  logic right_fill;

  // Variant picks the fill bit for an upward shift
  assign right_fill = RIGHT_ONLY ? (ctrl.source_sel ? d1_sync : d0_sync)
                                 : sr_sync;

  always_comb begin
    next_q = q;
    case (op)
      OP_CLEAR:      next_q = '0;
      OP_HOLD:       next_q = q;
      OP_SHIFT_UP:   next_q = shift_up(q, right_fill);
      OP_SHIFT_DOWN: next_q = shift_down(q, sl_sync);
      OP_ARITH:      next_q = shift_up(q, q[0]);
      OP_LOAD:       next_q = bus_s2;
      OP_NONE:       next_q = q;
      default:       next_q = q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Serial outputs are the end flops themselves
  assign low_end_serial_out  = q[0];
  assign high_end_serial_out = q[DATA_W-1];

  // Bus drive; controls only gate drivers, never the sequencing
  always_comb begin
    if (RIGHT_ONLY) begin
      bus_hiz = ctrl.bus_drive_off_a
                || (!clr_n_sync && !ctrl.hold && !ctrl.serial_par);
    end else begin
      bus_hiz = ctrl.bus_drive_off_a || ctrl.bus_drive_off_b;
    end
    // A load samples the pins, so our drivers must be off then
    if (op == OP_LOAD) begin
      bus_hiz = 1'b1;
    end
  end

  assign bus_out  = q;
  assign bus_oe_n = {DATA_W{bus_hiz}};

  // Read data
  logic [APB_DW-1:0] rd_word;

  always_comb begin
    rd_word = RD_ZERO;
    if (paddr == CTRL_ADDR) begin
      rd_word[CTRL_W-1:0] = ctrl;
    end else if (paddr == STATUS_ADDR) begin
      rd_word[DATA_W-1:0]     = q;
      rd_word[ST_LOW_OUT_POS]  = q[0];
      rd_word[ST_HIGH_OUT_POS] = q[DATA_W-1];
      rd_word[ST_HIZ_POS]      = bus_hiz;
    end
  end

  assign prdata = rd_fire ? rd_word : RD_ZERO;

endmodule

// >>> hw/shreg_pkg.sv
package shreg_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned APB_AW   = 12;
  localparam int unsigned APB_DW   = 32;

  // Register byte addresses
  localparam logic [APB_AW-1:0] CTRL_ADDR   = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h004;
  localparam logic [APB_AW-1:0] STEP_ADDR   = 12'h008;

  // Field positions in the status word
  localparam int unsigned ST_LOW_OUT_POS  = 8;
  localparam int unsigned ST_HIGH_OUT_POS = 9;
  localparam int unsigned ST_HIZ_POS      = 10;
  localparam int unsigned CTRL_W          = 9;

  // Synchroniser slots for the single-bit pins
  localparam int unsigned PIN_W   = 6;
  localparam int unsigned PIN_CLK = 5;
  localparam int unsigned PIN_CLR = 4;
  localparam int unsigned PIN_SL  = 3;
  localparam int unsigned PIN_SR  = 2;
  localparam int unsigned PIN_D0  = 1;
  localparam int unsigned PIN_D1  = 0;

  // Control word, bit 0 is mode_sel_low
  typedef struct packed {
    logic sign_extend_n;   // 8: low gives arithmetic shift
    logic source_sel;      // 7: serial_in_one when high
    logic serial_par;      // 6: high shifts, low loads
    logic hold;            // 5: right-shift variant hold
    logic bus_drive_off_b; // 4
    logic bus_drive_off_a; // 3: also the right-shift output enable
    logic spare;           // 2
    logic mode_sel_high;   // 1
    logic mode_sel_low;    // 0
  } ctrl_t;

  // Safe start: hold, bus released, sign extension off
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h138;
  localparam logic [APB_DW-1:0] RD_ZERO    = 32'h0000_0000;

  typedef enum {
    OP_NONE,
    OP_CLEAR,
    OP_HOLD,
    OP_SHIFT_UP,
    OP_SHIFT_DOWN,
    OP_ARITH,
    OP_LOAD
  } op_t;

endpackage

// >>> dv/shreg_checker_assertions.sv
`timescale 1ns/1ps
module shreg_checker
  import shreg_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic              clear_n,
  input wire logic              left_serial_in,
  input wire logic              right_serial_in,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic [DATA_W-1:0] bus_out,
  input wire logic [DATA_W-1:0] bus_oe_n,
  input wire logic              low_end_serial_out,
  input wire logic              high_end_serial_out
);
  logic [CTRL_W-1:0] ctrl;
  logic              wr;
  logic              step;
  assign wr   = psel && penable && pwrite;
  assign step = wr && paddr == STEP_ADDR;
  // Shadow of the control word, tracked from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl <= CTRL_RESET;
    else if (wr && paddr == CTRL_ADDR) ctrl <= pwdata[CTRL_W-1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pin levels pass two sync flops, hence the depth of three
  ser_low_a: assert property (low_end_serial_out == bus_out[0])
    else $error("low serial out");
  ser_high_a: assert property (high_end_serial_out == bus_out[7])
    else $error("high serial out");
  bus_hiz_a: assert property ((ctrl[3] | ctrl[4]) |-> &bus_oe_n)
    else $error("bus not released");
  hold_keep_a: assert property (step && ctrl[1:0] == 2'b00
    && $past(clear_n, 2) |=> $stable(bus_out)) else $error("hold");
  shift_up_a: assert property (step && ctrl[1:0] == 2'b10 && $past(clear_n, 2)
    |=> bus_out == {$past(bus_out[6:0]), $past(right_serial_in, 3)})
    else $error("shift up");
  shift_down_a: assert property (step && ctrl[1:0] == 2'b01 && $past(clear_n, 2)
    |=> bus_out == {$past(left_serial_in, 3), $past(bus_out[7:1])})
    else $error("shift down");
  load_a: assert property (step && ctrl[1:0] == 2'b11
    |=> bus_out == $past(bus_in, 3)) else $error("load");
  sync_clear_a: assert property (step && ctrl[1:0] != 2'b11
    && !$past(clear_n, 2) |=> bus_out == 8'h00) else $error("clear");
endmodule
bind octal_shift_register_bus_io shreg_checker shreg_checker_i (.*);

// >>> dv/bus_partner.sv
`timescale 1ns/1ps
module bus_partner
  import shreg_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [DATA_W-1:0] bus_out,
  input  wire logic [DATA_W-1:0] bus_oe_n,
  input  wire logic              host_en,
  input  wire logic [DATA_W-1:0] host_data,
  output logic      [DATA_W-1:0] bus_in
);
  logic [DATA_W-1:0] last = '0;
  always_ff @(posedge pclk) last <= bus_in;
  // Undriven bus flips each cycle so stale data never looks valid
  always_comb begin
    if (bus_oe_n == '0) bus_in = bus_out;
    else if (host_en) bus_in = host_data;
    else bus_in = ~last;
  end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import shreg_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, shift_clk = 0, clear_n = 1, host_en = 0;
  logic left_serial_in = 0, right_serial_in = 0;
  logic serial_in_zero = 0, serial_in_one = 0;
  logic low_end_serial_out, high_end_serial_out;
  logic [DATA_W-1:0] bus_in, bus_out, bus_oe_n, host_data = '0;
  int err_count = 0, samples_checked = 0;
  octal_shift_register_bus_io octal_shift_register_bus_io_i (.*);
  bus_partner bus_partner_i (.*);
  always #20 pclk = ~pclk;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  function automatic logic [31:0] st(input logic [7:0] q, input logic z);
    return {21'h0, z, q[7], q[0], q};
  endfunction
  task automatic rdc(input logic [31:0] x);
    apb(0, STATUS_ADDR, 0);
    chk("status", x, r);
  endtask
  task automatic t_load;
    host_en <= 1;
    host_data <= 8'ha5;
    apb(1, CTRL_ADDR, 32'h01b);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'ha5, 1));
  endtask
  task automatic t_shift;
    right_serial_in <= 1;
    apb(1, CTRL_ADDR, 32'h002);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'h4b, 0));
    chk("oe", 0, bus_oe_n);
    apb(1, CTRL_ADDR, 32'h001);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'h25, 0));
  endtask
  task automatic t_hold;
    apb(1, CTRL_ADDR, 32'h000);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'h25, 0));
    rdc(st(8'h25, 0));
  endtask
  task automatic t_clear;
    clear_n <= 0;
    host_data <= 8'h3c;
    apb(1, CTRL_ADDR, 32'h01b);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'h3c, 1));
    apb(1, CTRL_ADDR, 32'h019);
    apb(1, STEP_ADDR, 0);
    rdc(st(8'h00, 1));
    clear_n <= 1;
    apb(0, 12'h00c, 0);
    chk("slverr", 1, e);
  endtask
  task automatic t_pin;
    right_serial_in <= 1;
    apb(1, CTRL_ADDR, 32'h002);
    @(posedge pclk);
    shift_clk <= 1;
    repeat (4) @(posedge pclk);
    shift_clk <= 0;
    repeat (4) @(posedge pclk);
    rdc(st(8'h01, 0));
    chk("low out", 1, low_end_serial_out);
    chk("high out", 0, high_end_serial_out);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdc(st(8'h00, 1));
    t_load();
    t_shift();
    t_hold();
    t_clear();
    t_pin();
    give_verdict();
  end
  initial begin
    #100us;
    err_count++;
    give_verdict();
  end
endmodule
